// ===== dv/rpe_host.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// host bus driver
module rpe_host (
  input wire logic clk_in,
  output var rpe_pkg::rpe_req_t req_out
);
  initial req_out = '0;
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_in) #1 req_out = '{a, d, w, !w};
    @(posedge clk_in) #1 req_out = '0;
  endtask
endmodule
`default_nettype wire

// ===== dv/rpe_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// checks
module rpe_regs_props #(
  parameter int NUM_PORTS = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire rpe_pkg::rpe_req_t req_in,
  input wire rpe_pkg::rpe_evt_t [NUM_PORTS-1:0] evt_in,
  input wire logic [NUM_PORTS-1:0] camera_status_read_in,
  input wire logic floor_start_enable_in,
  input wire logic floor_enable_wr_in,
  input wire logic [7:0] rdata_out,
  input wire logic rvalid_out,
  input wire rpe_pkg::rpe_eq_cfg_t [NUM_PORTS-1:0] eq_cfg_out,
  input wire logic [NUM_PORTS-1:0] port_irq_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_read_answer: assert property (req_in.bus_rd |=> rvalid_out) else $error("no answer");
  a_answer_cause: assert property (rvalid_out |-> $past(req_in.bus_rd)) else $error("stray answer");
  a_irq_sum: assert property (irq_out == |port_irq_out) else $error("irq sum");
  a_eq_reset: assert property ($rose(rst_n_in) |->
    eq_cfg_out[0].manual_eq == 6'h18 && !eq_cfg_out[0].adapt_off) else $error("eq reset");
  a_limit_reset: assert property ($rose(rst_n_in) |->
    eq_cfg_out[0].equalizer_ceiling == 4'hF && eq_cfg_out[0].equalizer_start_floor == 4'h2
    && eq_cfg_out[0].floor_start_enable) else $error("limit reset");
  a_irq_reset: assert property ($rose(rst_n_in) |-> !irq_out) else $error("irq reset");
  a_cfg_stable: assert property (!req_in.bus_wr && !floor_enable_wr_in |=>
    $stable(eq_cfg_out)) else $error("cfg moved");
  a_irq_cause: assert property ($rose(port_irq_out[0]) |->
    $past(|evt_in[0] || req_in.bus_wr)) else $error("irq no cause");
  a_irq_latched: assert property ($fell(port_irq_out[0]) |->
    $past(req_in.bus_rd || req_in.bus_wr || camera_status_read_in[0])) else $error("irq lost");
endmodule
bind rpe_regs rpe_regs_props #(.NUM_PORTS(NUM_PORTS)) u_props (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .req_in(req_in), .evt_in(evt_in),
  .camera_status_read_in(camera_status_read_in), .floor_start_enable_in(floor_start_enable_in),
  .floor_enable_wr_in(floor_enable_wr_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
  .eq_cfg_out(eq_cfg_out), .port_irq_out(port_irq_out), .irq_out(irq_out));
`default_nettype wire

// ===== dv/rpe_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
// ====
// bench
module rpe_regs_tb_top;
  logic clk_in = 0, rst_n_in = 0, flr_wr = 0, flr_val = 0;
  rpe_pkg::rpe_req_t req;
  rpe_pkg::rpe_evt_t [1:0] evt = '0;
  logic [1:0] cam = '0, pirq;
  logic [7:0] rdata, d;
  logic rvalid, irq;
  rpe_pkg::rpe_eq_cfg_t [1:0] cfg;
  logic [8:0] expq[$], e;
  logic [9:0] m;
  logic [15:0] rt[7] = '{16'hD460, 16'hD5F2, 16'hD600, 16'hD700, 16'hD800, 16'hD900, 16'h1000};
  int n_fail = 0, compares = 0, c, f;
  rpe_host u_host (.clk_in(clk_in), .req_out(req));
  rpe_regs #(.NUM_PORTS(2)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req),
    .evt_in(evt), .camera_status_read_in(cam), .floor_start_enable_in(flr_val),
    .floor_enable_wr_in(flr_wr), .rdata_out(rdata), .rvalid_out(rvalid), .eq_cfg_out(cfg),
    .port_irq_out(pirq), .irq_out(irq));
  initial forever #20 clk_in = ~clk_in;
  task automatic results();
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // bit 8 of a note marks an unchecked answer
  task automatic rd(input logic [7:0] a, input logic [8:0] x);
    expq.push_back(x);
    u_host.xfer(a, 8'h00, 1'b0);
  endtask
  task automatic pulse(input logic [9:0] e0, input logic [9:0] e1, input logic [1:0] k);
    @(posedge clk_in) #1 evt = {e1, e0};
    cam = k;
    @(posedge clk_in) #1 evt = '0;
    cam = '0;
  endtask
  always @(posedge clk_in) begin
    if (rvalid) begin
      e = expq.pop_front();
      if (!e[8]) `CHK("rdata", e[7:0], rdata)
    end
  end
  initial begin
    void'($urandom(22));
    repeat (4) @(posedge clk_in);
    #1 rst_n_in = 1;
    u_host.xfer(8'h4C, 8'h01, 1'b1);
    foreach (rt[i]) rd(rt[i][15:8], {1'b0, rt[i][7:0]});
    d = 8'($urandom);
    u_host.xfer(8'h4C, 8'h02, 1'b1);
    u_host.xfer(8'hD4, d, 1'b1);
    `CHK("manual", {d[7:5], d[3:1]}, cfg[1].manual_eq)
    `CHK("bypass", d[0], cfg[1].adapt_off)
    `CHK("other", 6'h18, cfg[0].manual_eq)
    c = 1 + $urandom % 15;
    f = $urandom % c;
    u_host.xfer(8'hD5, {c[3:0], f[3:0]}, 1'b1);
    `CHK("ceil", c[3:0], cfg[1].equalizer_ceiling)
    `CHK("floor", f[3:0], cfg[1].equalizer_start_floor)
    @(posedge clk_in) #1 flr_wr = 1;
    @(posedge clk_in) #1 flr_wr = 0;
    `CHK("flren", 2'b01, {cfg[1].floor_start_enable, cfg[0].floor_start_enable})
    @(posedge clk_in) #1 flr_wr = 1;
    flr_val = 1;
    @(posedge clk_in) #1 flr_wr = 0;
    `CHK("flren1", 2'b11, {cfg[1].floor_start_enable, cfg[0].floor_start_enable})
    u_host.xfer(8'h4C, 8'h01, 1'b1);
    u_host.xfer(8'hD8, 8'hFF, 1'b1);
    rd(8'hD8, 9'h007);
    for (int i = 0; i < 10; i++) begin
      m = 10'h1 << i;
      u_host.xfer(8'hD8, {5'h0, m[9:7]}, 1'b1);
      u_host.xfer(8'hD9, {1'b0, m[6:0]}, 1'b1);
      pulse(~m, 10'($urandom), 2'b00);
      `CHK("masked", 2'b00, pirq)
      pulse(m, 10'h0, 2'b00);
      repeat (3) @(posedge clk_in);
      `CHK("irq", 1'b1, irq)
      rd(8'hDA, 9'h007);
      rd(8'hDB, 9'h07F);
      rd(8'hDC, 9'h100);
      rd(8'hDD, 9'h100);
      pulse(10'h0, 10'h0, 2'b01);
      `CHK("clear", 2'b00, pirq)
    end
    results();
  end
  initial begin
    #100000;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire

// ===== shared/rpe_defines.svh
`ifndef RPE_DEFINES_SVH
`define RPE_DEFINES_SVH
`define RPE_OFS_PORT_SEL 8'h4C
`define RPE_OFS_BYPASS 8'hD4
`define RPE_OFS_LIMITS 8'hD5
`define RPE_OFS_RSVD_A 8'hD6
`define RPE_OFS_RSVD_B 8'hD7
`define RPE_OFS_IE_HI 8'hD8
`define RPE_OFS_IE_LO 8'hD9
`define RPE_OFS_PEND_HI 8'hDA
`define RPE_OFS_PEND_LO 8'hDB
`define RPE_OFS_STS1 8'hDC
`define RPE_OFS_STS2 8'hDD
`define RPE_RST_BYPASS 8'h60
`define RPE_RST_LIMITS 8'hF2
`define RPE_RST_ZERO 8'h00
`define RPE_RST_FLOOR_EN 1'b1
`define RPE_MASK_IE_HI 8'h07
`define RPE_MASK_IE_LO 8'h7F
`define RPE_BIT_ADAPT_OFF 0
`define RPE_LSB_MAN_LO 1
`define RPE_LSB_MAN_HI 5
`define RPE_LSB_FLOOR 0
`define RPE_LSB_CEIL 4
`define RPE_HI_MASK_STS1 8'h03
`define RPE_LO_MASK_STS1 8'h07
`define RPE_HI_MASK_STS2 8'h04
`define RPE_LO_MASK_STS2 8'h70
`define RPE_LO_MASK_CAM 8'h08
`endif

// ===== shared/rpe_pkg.sv
package rpe_pkg;
  typedef struct packed {
    logic [7:0] bypass;
    logic [7:0] limits;
    logic [7:0] rsvd_a;
    logic [7:0] rsvd_b;
    logic [7:0] ie_hi;
    logic [7:0] ie_lo;
    logic [7:0] pend_hi;
    logic [7:0] pend_lo;
  } rpe_port_t;
  typedef struct packed {
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
  } rpe_req_t;
  // per-port event pulses: hi 2:0, lo 6:0 in enable-bit order
  typedef struct packed {
    logic [2:0] hi;
    logic [6:0] lo;
  } rpe_evt_t;
  typedef struct packed {
    logic adapt_off;
    logic [5:0] manual_eq;
    logic [3:0] equalizer_ceiling;
    logic [3:0] equalizer_start_floor;
    logic floor_start_enable;
  } rpe_eq_cfg_t;
endpackage

// ===== src/rpe_regs.sv
// Summary of operation
// - per-port copies chosen by port-select register
// - bypass low eq bits from 3:1
// - bypass high eq bits from 7:5
// - adaptation capped by ceiling field 7:4
// - floor field 3:0 starts adaptation
// - floor enable resets to one
// - encoding fault interrupt enable hi bit 2
// - control sequence fault enable hi bit 1
// - control crc fault enable hi bit 0
// - line length change enable lo bit 6
// - line count change enable lo bit 5
// - receive overflow enable lo bit 4
// - camera receiver fault enable lo bit 3
// - parity fault enable lo bit 2
// - port valid change enable lo bit 1
// - lock change enable lo bit 0
// - pending latched until status read clears
`timescale 1ns/1ps
`default_nettype none
`include "rpe_defines.svh"
module rpe_regs #(
  parameter int NUM_PORTS = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire rpe_pkg::rpe_req_t req_in,
  input wire rpe_pkg::rpe_evt_t [NUM_PORTS-1:0] evt_in,
  input wire logic [NUM_PORTS-1:0] camera_status_read_in,
  input wire logic floor_start_enable_in,
  input wire logic floor_enable_wr_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output rpe_pkg::rpe_eq_cfg_t [NUM_PORTS-1:0] eq_cfg_out,
  output logic [NUM_PORTS-1:0] port_irq_out,
  output logic irq_out
);
  typedef struct packed {
    logic [7:0] port_sel;
    rpe_pkg::rpe_port_t [NUM_PORTS-1:0] port;
    logic [NUM_PORTS-1:0] floor_en;
    logic [7:0] rdata;
    logic rvalid;
  } rpe_state_t;
  rpe_state_t st_r;
  rpe_state_t st_nxt;
  // ==========================================================
  // next state
  always_comb begin
    logic [7:0] sts;
    logic [7:0] ph;
    logic [7:0] pl;
    st_nxt = st_r;
    sts = 8'h00;
    ph = 8'h00;
    pl = 8'h00;
    st_nxt.rvalid = req_in.bus_rd;
    if (req_in.bus_wr && req_in.bus_addr == `RPE_OFS_PORT_SEL) begin
      st_nxt.port_sel = req_in.bus_wdata;
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (st_r.port_sel[p] && req_in.bus_wr) begin
        case (req_in.bus_addr)
          `RPE_OFS_BYPASS: st_nxt.port[p].bypass = req_in.bus_wdata;
          `RPE_OFS_LIMITS: st_nxt.port[p].limits = req_in.bus_wdata;
          `RPE_OFS_RSVD_A: st_nxt.port[p].rsvd_a = req_in.bus_wdata;
          `RPE_OFS_RSVD_B: st_nxt.port[p].rsvd_b = req_in.bus_wdata;
          `RPE_OFS_IE_HI: st_nxt.port[p].ie_hi = req_in.bus_wdata & `RPE_MASK_IE_HI;
          `RPE_OFS_IE_LO: st_nxt.port[p].ie_lo = req_in.bus_wdata;
          default: st_nxt.port[p].ie_lo = st_nxt.port[p].ie_lo;
        endcase
      end
      if (floor_enable_wr_in && st_r.port_sel[p]) begin
        st_nxt.floor_en[p] = floor_start_enable_in;
      end
      // read of status register clears pending
      if (st_r.port_sel[p] && req_in.bus_rd && req_in.bus_addr == `RPE_OFS_STS1) begin
        ph = ph | `RPE_HI_MASK_STS1;
        pl = pl | `RPE_LO_MASK_STS1;
      end
      if (st_r.port_sel[p] && req_in.bus_rd && req_in.bus_addr == `RPE_OFS_STS2) begin
        ph = ph | `RPE_HI_MASK_STS2;
        pl = pl | `RPE_LO_MASK_STS2;
      end
      if (camera_status_read_in[p]) begin
        pl = pl | `RPE_LO_MASK_CAM;
      end
      st_nxt.port[p].pend_hi = (st_r.port[p].pend_hi & ~ph) | {5'b0_0000, evt_in[p].hi};
      st_nxt.port[p].pend_lo = (st_r.port[p].pend_lo & ~pl) | {1'b0, evt_in[p].lo};
      ph = 8'h00;
      pl = 8'h00;
    end
    // read mux: lowest selected port answers
    if (req_in.bus_rd) begin
      st_nxt.rdata = 8'h00;
      for (int p = NUM_PORTS - 1; p >= 0; p--) begin
        if (st_r.port_sel[p]) begin
          case (req_in.bus_addr)
            `RPE_OFS_BYPASS: sts = st_r.port[p].bypass;
            `RPE_OFS_LIMITS: sts = st_r.port[p].limits;
            `RPE_OFS_RSVD_A: sts = st_r.port[p].rsvd_a;
            `RPE_OFS_RSVD_B: sts = st_r.port[p].rsvd_b;
            `RPE_OFS_IE_HI: sts = st_r.port[p].ie_hi;
            `RPE_OFS_IE_LO: sts = st_r.port[p].ie_lo;
            `RPE_OFS_PEND_HI: sts = st_r.port[p].pend_hi;
            `RPE_OFS_PEND_LO: sts = st_r.port[p].pend_lo;
            default: sts = 8'h00;
          endcase
          st_nxt.rdata = sts;
        end
      end
      if (req_in.bus_addr == `RPE_OFS_PORT_SEL) begin
        st_nxt.rdata = st_r.port_sel;
      end
    end
  end
  // ==========================================================
  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r.port_sel <= `RPE_RST_ZERO;
      st_r.rdata <= `RPE_RST_ZERO;
      st_r.rvalid <= 1'b0;
      st_r.floor_en <= {NUM_PORTS{`RPE_RST_FLOOR_EN}};
      for (int p = 0; p < NUM_PORTS; p++) begin
        st_r.port[p].bypass <= `RPE_RST_BYPASS;
        st_r.port[p].limits <= `RPE_RST_LIMITS;
        st_r.port[p].rsvd_a <= `RPE_RST_ZERO;
        st_r.port[p].rsvd_b <= `RPE_RST_ZERO;
        st_r.port[p].ie_hi <= `RPE_RST_ZERO;
        st_r.port[p].ie_lo <= `RPE_RST_ZERO;
        st_r.port[p].pend_hi <= `RPE_RST_ZERO;
        st_r.port[p].pend_lo <= `RPE_RST_ZERO;
      end
    end else begin
      st_r <= st_nxt;
    end
  end
  // ==========================================================
  // outputs
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      logic [9:0] gated;
      assign eq_cfg_out[g].adapt_off = st_r.port[g].bypass[`RPE_BIT_ADAPT_OFF];
      assign eq_cfg_out[g].manual_eq[2:0] = st_r.port[g].bypass[`RPE_LSB_MAN_LO +: 3];
      assign eq_cfg_out[g].manual_eq[5:3] = st_r.port[g].bypass[`RPE_LSB_MAN_HI +: 3];
      assign eq_cfg_out[g].equalizer_ceiling = st_r.port[g].limits[`RPE_LSB_CEIL +: 4];
      assign eq_cfg_out[g].equalizer_start_floor = st_r.port[g].limits[`RPE_LSB_FLOOR +: 4];
      assign eq_cfg_out[g].floor_start_enable = st_r.floor_en[g];
      assign gated[0] = st_r.port[g].pend_lo[0] & st_r.port[g].ie_lo[0];
      assign gated[1] = st_r.port[g].pend_lo[1] & st_r.port[g].ie_lo[1];
      assign gated[2] = st_r.port[g].pend_lo[2] & st_r.port[g].ie_lo[2];
      assign gated[3] = st_r.port[g].pend_lo[3] & st_r.port[g].ie_lo[3];
      assign gated[4] = st_r.port[g].pend_lo[4] & st_r.port[g].ie_lo[4];
      assign gated[5] = st_r.port[g].pend_lo[5] & st_r.port[g].ie_lo[5];
      assign gated[6] = st_r.port[g].pend_lo[6] & st_r.port[g].ie_lo[6];
      assign gated[7] = st_r.port[g].pend_hi[0] & st_r.port[g].ie_hi[0];
      assign gated[8] = st_r.port[g].pend_hi[1] & st_r.port[g].ie_hi[1];
      assign gated[9] = st_r.port[g].pend_hi[2] & st_r.port[g].ie_hi[2];
      assign port_irq_out[g] = |gated;
    end
  endgenerate
  assign irq_out = |port_irq_out;
  assign rdata_out = st_r.rdata;
  assign rvalid_out = st_r.rvalid;
endmodule
`default_nettype wire
